//--- ispp_pkg.sv
package ispp_pkg;

    // ------------------------------------------------------------
    // Data shape
    // ------------------------------------------------------------
    localparam int             BYTE_W      = 8;
    localparam int             IDX_W       = 3;
    localparam logic [2:0]     BIT_LAST    = 3'h7;
    localparam logic [7:0]     IDLE_BYTE   = 8'hFF;

    // ------------------------------------------------------------
    // Packet header positions and values
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_PRE0    = 3'h0;
    localparam logic [IDX_W-1:0] IDX_PRE1    = 3'h1;
    localparam logic [IDX_W-1:0] IDX_OPCODE  = 3'h2;
    localparam logic [IDX_W-1:0] IDX_ADDR_HI = 3'h3;
    localparam logic [IDX_W-1:0] IDX_MAX     = 3'h4;
    localparam logic [7:0]       PREAMBLE_0  = 8'hAA;
    localparam logic [7:0]       PREAMBLE_1  = 8'h55;
    localparam logic [7:0]       OPC_ENABLE  = 8'hAC;
    localparam logic [7:0]       SUB_PROG_EN = 8'h53;
    localparam logic [7:0]       SUB_PAR_EN  = 8'h35;

    // ------------------------------------------------------------
    // Timing: 25 MHz system clock, link clock at most 5 MHz
    // ------------------------------------------------------------
    localparam int             SYS_CLK_KHZ  = 25000;
    localparam int             SCK_MAX_KHZ  = 5000;
    // Half period rounded up so the link never runs too fast
    localparam int             SCK_HALF_CYC =
        (SYS_CLK_KHZ + 2 * SCK_MAX_KHZ - 1) / (2 * SCK_MAX_KHZ);
    localparam int             HALF_W       = 4;
    localparam logic [HALF_W-1:0] HALF_CNT  = 4'(SCK_HALF_CYC - 1);

endpackage : ispp_pkg

//--- ispp_if.sv
`timescale 1ns/1ps

interface ispp_if;

    logic                         sck;
    logic                         ss_n;
    logic                         rst_n;
    logic                         mosi;
    logic                         miso;
    logic                         miso_oe;
    logic [ispp_pkg::BYTE_W-1:0]  par_host;
    logic                         par_host_oe;
    logic [ispp_pkg::BYTE_W-1:0]  par_dev;
    logic                         par_dev_oe;
    logic [ispp_pkg::BYTE_W-1:0]  par_bus;

    // Shared byte port level; device drive wins on overlap
    assign par_bus = par_dev_oe ? par_dev : par_host;

    modport dev (
        input  sck,
        input  ss_n,
        input  rst_n,
        input  mosi,
        input  par_bus,
        output miso,
        output miso_oe,
        output par_dev,
        output par_dev_oe
    );

    modport prog (
        output sck,
        output ss_n,
        output rst_n,
        output mosi,
        output par_host,
        output par_host_oe,
        input  miso,
        input  par_bus
    );

endinterface : ispp_if

//--- ispp_prog.sv
`timescale 1ns/1ps

module ispp_prog (
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    ispp_if.prog                             link,
    input  wire logic                        hold_target_reset,
    input  wire logic                        par_format,
    input  wire logic                        tx_valid,
    input  wire logic [ispp_pkg::BYTE_W-1:0] tx_data,
    input  wire logic                        tx_rd,
    input  wire logic                        tx_last,
    output logic                             tx_ready,
    output logic [ispp_pkg::BYTE_W-1:0]      rx_data,
    output logic                             rx_valid
);
    import ispp_pkg::*;

    typedef enum logic [1:0] {
        HS_IDLE = 2'h0,
        HS_LOW  = 2'h1,
        HS_HIGH = 2'h3,
        HS_END  = 2'h2
    } ispp_hstate_e;

    ispp_hstate_e       state;
    logic [HALF_W-1:0]  hc;
    logic [2:0]         bits;
    logic [BYTE_W-1:0]  sh;
    logic [BYTE_W-1:0]  rx_sh;
    logic               last;
    logic               rd;
    logic               need;
    logic               take;
    logic               byte_end;
    logic               rise_ev;
    logic               fall_ev;
    logic [BYTE_W:0]    in_s1;
    logic [BYTE_W:0]    in_s2;

    assign take     = tx_valid & tx_ready;
    assign byte_end = par_format | (bits == BIT_LAST);
    assign rise_ev  = (state == HS_LOW) & ~need & (hc == '0);
    assign fall_ev  = (state == HS_HIGH) & (hc == '0);

    // ------------------------------------------------------------
    // Target reset and input synchronisers
    // ------------------------------------------------------------
    // programmer owns reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            link.rst_n <= 1'h1;
        end else begin
            link.rst_n <= ~hold_target_reset;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            in_s1 <= '0;
            in_s2 <= '0;
        end else begin
            in_s1 <= {link.miso, link.par_bus};
            in_s2 <= in_s1;
        end
    end

    // ------------------------------------------------------------
    // Frame sequencer and link clock divider
    // ------------------------------------------------------------
    // master drives clock
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state            <= HS_IDLE;
            hc               <= '0;
            bits             <= '0;
            sh               <= '0;
            last             <= 1'h0;
            rd               <= 1'h0;
            need             <= 1'h0;
            tx_ready         <= 1'h0;
            link.sck         <= 1'h0;
            link.ss_n        <= 1'h1;
            link.mosi        <= 1'h1;
            link.par_host    <= '0;
            link.par_host_oe <= 1'h0;
        end else begin
            case (state)
                HS_IDLE: begin
                    tx_ready <= 1'h0;
                    if (tx_valid) begin
                        state     <= HS_LOW;
                        need      <= 1'h1;
                        tx_ready  <= 1'h1;
                        link.ss_n <= 1'h0;
                    end
                end
                HS_LOW: begin
                    if (need) begin
                        if (take) begin
                            need             <= 1'h0;
                            tx_ready         <= 1'h0;
                            hc               <= HALF_CNT;
                            bits             <= '0;
                            sh               <= tx_data;
                            last             <= tx_last;
                            rd               <= tx_rd;
                            link.par_host    <= tx_data;
                            link.par_host_oe <= par_format & ~tx_rd;
                            link.mosi <= par_format ? ~tx_rd
                                                    : tx_data[BYTE_W-1];
                        end
                    end else if (hc != '0) begin
                        hc <= hc - 1'h1;
                    end else begin
                        state    <= HS_HIGH;
                        hc       <= HALF_CNT;
                        link.sck <= 1'h1;
                    end
                end
                HS_HIGH: begin
                    if (hc != '0) begin
                        hc <= hc - 1'h1;
                    end else begin
                        link.sck <= 1'h0;
                        hc       <= HALF_CNT;
                        if (!byte_end) begin
                            state     <= HS_LOW;
                            bits      <= bits + 3'h1;
                            sh        <= {sh[BYTE_W-2:0], 1'h0};
                            link.mosi <= sh[BYTE_W-2];
                        end else if (last) begin
                            state <= HS_END;
                        end else begin
                            state    <= HS_LOW;
                            need     <= 1'h1;
                            tx_ready <= 1'h1;
                        end
                    end
                end
                HS_END: begin
                    if (hc != '0) begin
                        hc <= hc - 1'h1;
                    end else begin
                        state            <= HS_IDLE;
                        link.ss_n        <= 1'h1;
                        link.mosi        <= 1'h1;
                        link.par_host_oe <= 1'h0;
                    end
                end
                default: begin
                    state <= HS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Returned data
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_sh    <= '0;
            rx_data  <= '0;
            rx_valid <= 1'h0;
        end else begin
            rx_valid <= 1'h0;
            if (rise_ev && !par_format) begin
                rx_sh <= {rx_sh[BYTE_W-2:0], in_s2[BYTE_W]};
            end
            if (fall_ev && byte_end && (!par_format || rd)) begin
                rx_valid <= 1'h1;
                rx_data  <= par_format ? in_s2[BYTE_W-1:0] : rx_sh;
            end
        end
    end

endmodule : ispp_prog

//--- ispp_dev.sv
`timescale 1ns/1ps
module ispp_dev (
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    ispp_if.dev                              link,
    input  wire logic                        por_active,
    input  wire logic                        programming_entry_fuse,
    input  wire logic                        rst_pin_io,
    input  wire logic [ispp_pkg::BYTE_W-1:0] rd_data,
    input  wire logic                        rd_load,
    output logic                             prog_mode,
    output logic                             prog_enabled,
    output logic                             par_mode,
    output logic [ispp_pkg::BYTE_W-1:0]      rx_data,
    output logic [ispp_pkg::IDX_W-1:0]       rx_index,
    output logic                             rx_valid,
    output logic                             cmd_done
);
    import ispp_pkg::*;
    // System domain
    logic [1:0]         pin_sync;
    logic [BYTE_W-1:0]  tx_hold;
    logic               tx_tog;
    logic [3:0]         xs1;
    logic [3:0]         xs2;
    logic [1:0]         xs_prev;
    // Link domain
    logic               session_off, frame_rst, par_off;
    logic [1:0]         live_sync;
    logic [1:0]         tx_sync;
    logic [2:0]         bit_cnt;
    logic [IDX_W-1:0]   byte_idx;
    logic [IDX_W-1:0]   rx_idx_hold;
    logic               hdr_ok, pe_hit, par_hit;
    logic               prog_en_l, par_l;
    logic               byte_end, ld_slot;
    logic               rx_tog, done_tog;
    logic               tx_seen, tx_fresh;
    logic [BYTE_W-1:0]  shreg, byte_val, rx_hold;
    logic [BYTE_W-1:0]  tx_byte, tx_next;
    // ------------------------------------------------------------
    // Entry into programming (system clock)
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_sync <= 2'h3;
        end else begin
            pin_sync <= {pin_sync[0], link.rst_n};
        end
    end
    // exit at pin high; re-entry needs the pin low plus por_active, or the fuse with rst_pin_io low
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prog_mode <= 1'h0;
        end else begin
            prog_mode <= ~pin_sync[1] & (prog_mode | por_active
                       | (programming_entry_fuse & ~rst_pin_io));
        end
    end
    // Read byte handed over with a toggle; word held until next load
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_hold <= IDLE_BYTE;
            tx_tog  <= 1'h0;
        end else if (rd_load) begin
            tx_hold <= rd_data;
            tx_tog  <= ~tx_tog;
        end
    end
    // ------------------------------------------------------------
    // Link domain resets
    // ------------------------------------------------------------
    // Link clock stops between frames: select clears frame state
    assign session_off = ~prog_mode;
    assign frame_rst   = link.ss_n | rst;
    // end of read select releases the port at once
    assign par_off     = link.ss_n | link.mosi | rst;
    always_ff @(posedge link.sck or posedge session_off) begin
        if (session_off) begin
            live_sync <= 2'h0;
        end else begin
            live_sync <= {live_sync[0], 1'h1};
        end
    end
    // ------------------------------------------------------------
    // Byte assembly (link clock)
    // ------------------------------------------------------------
    always_comb begin
        byte_end = par_l ? link.mosi : (bit_cnt == BIT_LAST);
        byte_val = par_l ? link.par_bus : {shreg[BYTE_W-2:0], link.mosi};
        ld_slot  = par_l ? ~link.mosi : (bit_cnt == BIT_LAST);
        tx_fresh = tx_sync[1] != tx_seen;
        tx_next  = tx_fresh ? tx_hold : IDLE_BYTE;
    end
    always_ff @(posedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            shreg   <= '0;
            bit_cnt <= '0;
        end else if (!par_l) begin
            shreg   <= byte_val;
            bit_cnt <= bit_cnt + 3'h1;
        end
    end
    always_ff @(posedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            byte_idx <= '0;
            hdr_ok   <= 1'h1;
            pe_hit   <= 1'h0;
            par_hit  <= 1'h0;
        end else if (byte_end) begin
            if (byte_idx != IDX_MAX) begin
                byte_idx <= byte_idx + 3'h1;
            end
            case (byte_idx)
                IDX_PRE0: begin
                    hdr_ok <= hdr_ok & (byte_val == PREAMBLE_0);
                end
                IDX_PRE1: begin
                    hdr_ok <= hdr_ok & (byte_val == PREAMBLE_1);
                end
                IDX_OPCODE: begin
                    hdr_ok <= hdr_ok & (byte_val == OPC_ENABLE);
                end
                IDX_ADDR_HI: begin
                    pe_hit  <= hdr_ok & (byte_val == SUB_PROG_EN);
                    par_hit <= hdr_ok & (byte_val == SUB_PAR_EN);
                end
                default: ;
            endcase
        end
    end
    always_ff @(posedge link.sck or posedge rst) begin
        if (rst) begin
            rx_hold     <= '0;
            rx_idx_hold <= '0;
            rx_tog      <= 1'h0;
        end else if (byte_end && prog_en_l) begin
            rx_hold     <= byte_val;
            rx_idx_hold <= byte_idx;
            rx_tog      <= ~rx_tog;
        end
    end
    // ------------------------------------------------------------
    // Command commit on select rising edge
    // ------------------------------------------------------------
    // commit at end of frame
    always_ff @(posedge link.ss_n or posedge session_off) begin
        if (session_off) begin
            prog_en_l <= 1'h0;
            par_l     <= 1'h0;
        end else begin
            if (pe_hit && live_sync[1]) begin
                prog_en_l <= 1'h1;
            end
            if (par_hit && prog_en_l) begin
                par_l <= 1'h1;
            end
        end
    end
    always_ff @(posedge link.ss_n or posedge rst) begin
        if (rst) begin
            done_tog <= 1'h0;
        end else if (prog_en_l) begin
            done_tog <= ~done_tog;
        end
    end
    // ------------------------------------------------------------
    // Output bytes (link clock)
    // ------------------------------------------------------------
    always_ff @(posedge link.sck or posedge rst) begin
        if (rst) begin
            tx_sync <= 2'h0;
        end else begin
            tx_sync <= {tx_sync[0], tx_tog};
        end
    end
    always_ff @(posedge link.sck or posedge rst) begin
        if (rst) begin
            tx_seen <= 1'h0;
            tx_byte <= IDLE_BYTE;
        end else if (ld_slot) begin
            tx_seen <= tx_sync[1];
            tx_byte <= tx_next;
        end
    end
    assign link.par_dev = tx_byte;
    always_ff @(posedge link.sck or posedge par_off) begin
        if (par_off) begin
            link.par_dev_oe <= 1'h0;
        end else begin
            link.par_dev_oe <= par_l;
        end
    end
    always_ff @(negedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            link.miso    <= 1'h1;
            link.miso_oe <= 1'h0;
        end else begin
            link.miso    <= tx_byte[BIT_LAST - bit_cnt];
            link.miso_oe <= ~par_l;
        end
    end
    // ------------------------------------------------------------
    // Crossing back to the system clock
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            xs1     <= 4'h0;
            xs2     <= 4'h0;
            xs_prev <= 2'h0;
        end else begin
            xs1     <= {rx_tog, done_tog, prog_en_l, par_l};
            xs2     <= xs1;
            xs_prev <= xs2[3:2];
        end
    end
    assign prog_enabled = xs2[1];
    assign par_mode     = xs2[0];
    // Hold word read three cycles after its toggle; bytes come slower
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_data  <= '0;
            rx_index <= '0;
            rx_valid <= 1'h0;
            cmd_done <= 1'h0;
        end else begin
            rx_valid <= xs2[3] ^ xs_prev[1];
            cmd_done <= xs2[2] ^ xs_prev[0];
            if (xs2[3] ^ xs_prev[1]) begin
                rx_data  <= rx_hold;
                rx_index <= rx_idx_hold;
            end
        end
    end
endmodule : ispp_dev

//--- ispp_sva.sv
`timescale 1ns/1ps

module ispp_sva (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sck,
    input wire logic ss_n,
    input wire logic rst_n,
    input wire logic mosi,
    input wire logic miso_oe,
    input wire logic par_dev_oe,
    input wire logic par_host_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // ------------------------------
    // Link timing and drive
    // ------------------------------
    chk_sck_idle: assert property (ss_n |-> !sck)
        else $error("sck high outside frame");
    chk_sck_high_len: assert property ($rose(sck) |-> sck[*3] ##1 !sck)
        else $error("sck high phase not 3 cycles");
    chk_sck_low_len: assert property ($fell(sck) |-> !sck[*3])
        else $error("sck low phase too short");
    chk_mosi_hold: assert property (sck && $past(sck) |-> $stable(mosi))
        else $error("mosi moved while sck high");
    chk_idle_mosi: assert property (ss_n && $past(ss_n) |-> mosi)
        else $error("mosi low outside frame");
    chk_miso_idle: assert property (ss_n && $past(ss_n) |-> !miso_oe)
        else $error("miso driven outside frame");
    chk_miso_prog: assert property (miso_oe |-> !rst_n)
        else $error("miso driven with reset pin high");
    chk_read_sel: assert property ((mosi || ss_n)[*2] |-> !par_dev_oe)
        else $error("byte port driven without read select");
    chk_bus_contend: assert property (!(par_host_oe && par_dev_oe))
        else $error("byte port driven from both ends");

    cov_frame: cover property ($fell(ss_n));
    cov_read: cover property ($rose(par_dev_oe));
    cov_exit: cover property ($rose(rst_n));
endmodule : ispp_sva

//--- isp_programming_port_phy_tb.sv
`timescale 1ns/1ps

module isp_programming_port_phy_tb;
    import ispp_pkg::*;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       hold = 1'b0;
    logic       par_format = 1'b0;
    logic       tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic       tx_rd = 1'b0;
    logic       tx_last = 1'b0;
    logic       tx_ready, hrv, drv, cmd_done;
    logic [7:0] hrx, drx;
    logic       por_active = 1'b0;
    logic       fuse = 1'b0;
    logic       pin_io = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic       rd_load = 1'b0;
    logic       prog_mode, prog_enabled, par_mode;
    logic [7:0] dq[$];
    logic [7:0] hq[$];
    logic [2:0] dix;
    logic [2:0] iq[$];
    int         done_n = 0;
    int         err_count = 0;
    int         total_checks = 0;

    always #20 clk_sys = ~clk_sys;

    ispp_if lnk ();
    ispp_prog ispp_prog_i (.clk_sys(clk_sys), .rst(rst), .link(lnk),
        .hold_target_reset(hold), .par_format(par_format),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_rd(tx_rd),
        .tx_last(tx_last), .tx_ready(tx_ready), .rx_data(hrx),
        .rx_valid(hrv));
    ispp_dev ispp_dev_i (.clk_sys(clk_sys), .rst(rst), .link(lnk),
        .por_active(por_active), .programming_entry_fuse(fuse),
        .rst_pin_io(pin_io), .rd_data(rd_data), .rd_load(rd_load),
        .prog_mode(prog_mode), .prog_enabled(prog_enabled),
        .par_mode(par_mode), .rx_data(drx), .rx_index(dix),
        .rx_valid(drv), .cmd_done(cmd_done));
    ispp_sva ispp_sva_i (.clk_sys(clk_sys), .rst(rst), .sck(lnk.sck),
        .ss_n(lnk.ss_n), .rst_n(lnk.rst_n), .mosi(lnk.mosi),
        .miso_oe(lnk.miso_oe), .par_dev_oe(lnk.par_dev_oe),
        .par_host_oe(lnk.par_host_oe));

    always @(posedge clk_sys) begin
        if (drv === 1'b1) dq.push_back(drx);
        if (drv === 1'b1) iq.push_back(dix);
        if (hrv === 1'b1) hq.push_back(hrx);
        if (cmd_done === 1'b1) done_n++;
    end

    // ------------------------------
    // Shared tasks
    // ------------------------------
    task chk(input logic c, input string m);
        total_checks++;
        if (c !== 1'b1) begin
            err_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk

    task send(input logic [7:0] d, input logic last, input logic rd);
        int n;
        @(posedge clk_sys);
        #1;
        tx_valid = 1'b1;
        tx_data = d;
        tx_last = last;
        tx_rd = rd;
        n = 0;
        while (tx_ready !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(n < 2000, "tx_ready never came");
        @(posedge clk_sys);
        #1;
        tx_valid = 1'b0;
    endtask : send

    // Serial frame of four bytes, then time to commit
    task frame(input logic [31:0] w);
        int n;
        hq.delete();
        for (int i = 0; i < 4; i++) send(w[31-8*i -: 8], i == 3, 1'b0);
        n = 0;
        while (lnk.ss_n !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        chk(n < 200, "frame never closed");
        repeat (8) @(posedge clk_sys);
        #1;
        chk(hq.size() == 4 && hq[3] === IDLE_BYTE, "serial reply");
    endtask : frame

    task enter(input logic por, input logic f, input logic io, input logic e);
        por_active = por;
        fuse = f;
        pin_io = io;
        hold = 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        chk(prog_mode === e, "entry outcome");
    endtask : enter

    task leave;
        hold = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        chk(prog_mode === 1'b0 && par_mode === 1'b0, "mode kept after exit");
    endtask : leave

    task summarize;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize

    initial begin
        #1_000_000;
        err_count++;
        summarize();
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        enter(1'b0, 1'b0, 1'b0, 1'b0);
        leave();
        enter(1'b0, 1'b1, 1'b1, 1'b0);
        leave();
        enter(1'b1, 1'b0, 1'b0, 1'b1);
        por_active = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        chk(prog_mode === 1'b1, "session lost after power-on");
        leave();
        enter(1'b0, 1'b0, 1'b0, 1'b0);
        leave();
        enter(1'b0, 1'b1, 1'b0, 1'b1);
        frame(32'hAA553000);
        chk(dq.size() == 0 && done_n == 0, "bytes before enable");
        frame(32'hAA55AC53);
        chk(prog_enabled === 1'b1, "program enable missed");
        frame(32'hAB55AC35);
        chk(par_mode === 1'b0, "bad preamble accepted");
        chk(dq.size() == 4 && dq[0] === 8'hAB, "serial byte order");
        frame(32'hAA55AC35);
        chk(par_mode === 1'b1 && done_n == 2, "parallel enable");
        rd_data = 8'h5A;
        rd_load = 1'b1;
        @(posedge clk_sys);
        #1;
        rd_load = 1'b0;
        dq.delete();
        hq.delete();
        iq.delete();
        par_format = 1'b1;
        for (int i = 0; i < 5; i++) send(8'h50 + 8'(i), 1'b0, 1'b0);
        send(8'h00, 1'b1, 1'b1);
        repeat (10) @(posedge clk_sys);
        #1;
        chk(dq.size() == 5 && dq[1] === 8'h51, "parallel write bytes");
        chk(dq[4] === 8'h54, "last parallel byte");
        chk(iq[0] === 3'h0 && iq[4] === IDX_MAX, "byte index");
        chk(hq.size() == 1 && hq[0] === 8'h5A, "parallel read byte");
        leave();
        par_format = 1'b0;
        summarize();
    end
endmodule : isp_programming_port_phy_tb
